/* File: rtl/ecd_cfg.svh */
`ifndef ECD_CFG_SVH
`define ECD_CFG_SVH

// register bus offsets and answers
`define ECD_REG_CTRL        4'h0
`define ECD_REG_STATE       4'h4
`define ECD_CTRL_RUN_RST    1'h1
`define ECD_RESP_OKAY       2'h0
`define ECD_RESP_SLVERR     2'h2

// status register bit positions
`define ECD_SR_LINK         7
`define ECD_SR_OVF          6
`define ECD_SR_SENSE_B      5
`define ECD_SR_SENSE_A      4
`define ECD_SR_IE           3

// reset values, wait end value and the displacement that selects ext
`define ECD_PTR_RST         16'h0000
`define ECD_BYTE_RST        8'h00
`define ECD_DLY_END         8'hFF
`define ECD_DISP_SUB        8'h80

// alu functions, taken from opcode bits 5:3
`define ECD_FN_LOAD         3'h0
`define ECD_FN_STORE        3'h1
`define ECD_FN_AND          3'h2
`define ECD_FN_OR           3'h3
`define ECD_FN_XOR          3'h4
`define ECD_FN_BCD          3'h5
`define ECD_FN_ADD          3'h6
`define ECD_FN_CADD         3'h7

// opcodes and opcode prefixes
`define ECD_OP_HALT         8'h00
`define ECD_OP_XAE          8'h01
`define ECD_OP_CLR_LINK     8'h02
`define ECD_OP_SET_LINK     8'h03
`define ECD_OP_INT_DIS      8'h04
`define ECD_OP_INT_ALLOW    8'h05
`define ECD_OP_SR_TO_ACC    8'h06
`define ECD_OP_ACC_TO_SR    8'h07
`define ECD_OP_SERIAL       8'h19
`define ECD_OP_SHR_ZERO     8'h1C
`define ECD_OP_SHR_LINK     8'h1D
`define ECD_OP_ROR          8'h1E
`define ECD_OP_ROR_LINK     8'h1F
`define ECD_OP_DELAY        8'h8F
`define ECD_PFX_PTR_LOW     6'h0C
`define ECD_PFX_PTR_HIGH    6'h0D
`define ECD_PFX_PTR_PC      6'h0F
`define ECD_PFX_INCR        6'h2A
`define ECD_PFX_DECR        6'h2E
`define ECD_PFX_JUMP        4'h9

// microcycle counts, one microcycle per mclk
`define ECD_UC_MEM          18'h00012
`define ECD_UC_MEM_BCD      18'h00017
`define ECD_UC_MEM_ADD      18'h00013
`define ECD_UC_MEM_CADD     18'h00014
`define ECD_UC_IMM_LESS     18'h00008
`define ECD_UC_EXT_LESS     18'h00004
`define ECD_UC_INCDEC       18'h00016
`define ECD_UC_JUMP         18'h0000B
`define ECD_UC_NO_JUMP      18'h00009
`define ECD_UC_DLY_BASE     18'h0000D
`define ECD_UC_DLY_PER_DATA 32'h00000202
`define ECD_UC_SWAP_EXT     18'h00007
`define ECD_UC_SWAP_PTR     18'h00008
`define ECD_UC_SWAP_PC      18'h00007
`define ECD_UC_SR_WRITE     18'h00006
`define ECD_UC_HALT         18'h00008
`define ECD_UC_SHORT        18'h00005

`endif

/* File: rtl/ecd_pkg.sv */
package ecd_pkg;

	typedef logic [2:0] ecd_func_type;

	typedef enum logic [3:0] {
		S_IDLE,
		S_IFW,
		S_OPF,
		S_OPW,
		S_EXEC,
		S_RDW,
		S_RES,
		S_WRW,
		S_PAD
	} ecd_state_type;

endpackage

/* File: rtl/ecd_alu.sv */
`timescale 1ns/100ps
`include "ecd_cfg.svh"

module ecd_alu (
	// operation
	input  wire ecd_pkg::ecd_func_type func,
	input  wire logic [7:0]            a,
	input  wire logic [7:0]            b,
	input  wire logic                  cin,
	// result
	output logic      [7:0]            res,
	output logic                       cout,
	output logic                       ovf
);
	import ecd_pkg::*;

	logic [7:0] bb;
	logic [8:0] sum9;
	logic [4:0] lo;
	logic [4:0] hi;
	logic       lo_c;
	logic       hi_c;

	always_comb begin
		bb   = (func == `ECD_FN_CADD) ? ~b : b;
		sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		lo_c = lo > 5'h09;
		hi   = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo_c};
		hi_c = hi > 5'h09;
		res  = a;
		cout = 1'b0;
		ovf  = 1'b0;
		case (func)
			`ECD_FN_LOAD: res = b;
			`ECD_FN_AND:  res = a & b;
			`ECD_FN_OR:   res = a | b;
			`ECD_FN_XOR:  res = a ^ b;
			`ECD_FN_BCD: begin
				res[3:0] = lo_c ? 4'(lo + 5'h06) : lo[3:0];
				res[7:4] = hi_c ? 4'(hi + 5'h06) : hi[3:0];
				cout     = hi_c;
			end
			`ECD_FN_ADD, `ECD_FN_CADD: begin
				res  = sum9[7:0];
				cout = sum9[8];
				ovf  = (a[7] == bb[7]) && (sum9[7] != a[7]);
			end
			default: res = a;
		endcase
	end

endmodule

/* File: rtl/ecd_ea.sv */
`timescale 1ns/100ps
`include "ecd_cfg.svh"

module ecd_ea (
	// address sources
	input  wire logic [15:0] base,
	input  wire logic [7:0]  disp,
	input  wire logic [7:0]  ext,
	input  wire logic        auto_mode,
	// results
	output logic      [15:0] ea,
	output logic      [15:0] new_ptr
);
	logic [7:0]  eff;
	logic [11:0] off;
	logic [15:0] sum;

	assign eff = (disp == `ECD_DISP_SUB) ? ext : disp;
	assign off = {{4{eff[7]}}, eff};
	assign sum = {base[15:12], 12'(base[11:0] + off)};
	// negative auto step updates first, positive after the access
	assign ea      = (auto_mode && !eff[7]) ? base : sum;
	assign new_ptr = auto_mode ? sum : base;

endmodule

/* File: rtl/ecd_core.sv */
// Operation
// - memory instructions also reach peripherals on the one shared bus
// - 46 instructions, one opcode byte or opcode plus one data byte
// - address arithmetic touches low 12 bits only, wraps in 4K page
// - upper four address bits are 0000 after reset
// - mode bit and pointer field pick PC-relative, indexed, immediate, auto
// - displacement 80 hex is replaced by the extension register
// - PC-relative address is PC plus sign-extended displacement
// - PC holds last byte of current instruction while forming addresses
// - immediate forms use the second byte as operand, no data access
// - indexed address is pointer plus displacement, pointer unchanged
// - auto mode, negative step: update pointer first, then access
// - auto mode, zero or positive step: access old pointer, then update
// - memory opcodes are five function bits, mode bit, pointer field
// - immediate forms end in 100; no immediate store
// - add and complement-add use link in, update link and overflow
// - increment and decrement fetch write back and load accumulator
// - jump opcodes; conditional jumps take 9 or 11 microcycles
// - timed wait counts accumulator to -1, 13+2A+514D microcycles
// - single-byte extension register operations and their encodings
// - swap accumulator with pointer low or high byte, pointer with PC
// - serial shift moves extension right, pin in, bit 0 out latch
// - right shift with zero or link, rotate, rotate through link
// - status bit 3 is interrupt allow, set by opcodes or status copy
// - link flag, status bit 7, takes carry out of all adds
// - overflow flag, status bit 6, signed overflow, kept by decimal add
// - serial output pin is a latch loaded only by the serial shift
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ecd_cfg.svh"

module ecd_core #(
	parameter int unsigned DLY_PER_DATA = `ECD_UC_DLY_PER_DATA
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// memory and peripheral bus
	output logic      [15:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_ready,
	// pins
	input  wire logic        sense_a_pin,
	input  wire logic        sense_b_pin,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic      [2:0]  flag_out,
	output logic             halt_pulse,
	// register bus
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import ecd_pkg::*;

	ecd_state_type state;
	logic [15:0]   ptr [4];
	logic [7:0]    acc;
	logic [7:0]    ext;
	logic [7:0]    sr_q;
	logic [7:0]    opcode;
	logic [7:0]    operand;
	logic [7:0]    mem_q;
	logic [15:0]   ea_q;
	logic [15:0]   nptr_q;
	logic          post_upd;
	logic [17:0]   elapsed;
	logic [17:0]   total;
	logic [2:0]    sync1;
	logic [2:0]    sync2;
	logic          run;
	logic          aw_got;
	logic          w_got;
	logic [3:0]    aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;

	logic [15:0]   pc_next;
	logic [7:0]    sr_view;
	logic [1:0]    p;
	ecd_func_type  fn;
	logic          is_mem;
	logic          is_imm;
	logic          is_incdec;
	logic          is_jump;
	logic          is_dly;
	logic          is_ext;
	logic          auto_mode;
	logic          jump_take;
	logic [15:0]   ea;
	logic [15:0]   new_ptr;
	logic [7:0]    alu_b;
	logic [7:0]    alu_res;
	logic          alu_cout;
	logic          alu_ovf;
	logic [7:0]    next_val;
	logic [17:0]   mem_uc;
	logic [17:0]   next_total;

	assign pc_next = {ptr[0][15:12], 12'(ptr[0][11:0] + 12'h001)};
	assign sr_view = {sr_q[7:6], sync2[1], sync2[0], sr_q[3:0]};
	assign p       = opcode[1:0];
	assign fn      = opcode[5:3];

	assign is_mem    = opcode[7:6] == 2'b11;
	assign is_imm    = is_mem && opcode[2] && (p == 2'b00);
	assign is_incdec = (opcode[7:2] == `ECD_PFX_INCR) || (opcode[7:2] == `ECD_PFX_DECR);
	assign is_jump   = opcode[7:4] == `ECD_PFX_JUMP;
	assign is_dly    = opcode == `ECD_OP_DELAY;
	assign is_ext    = (opcode[7:6] == 2'b01) && (opcode[2:0] == 3'b000);
	assign auto_mode = is_mem && opcode[2];
	assign alu_b     = !opcode[7] ? ext : (is_imm ? operand : mem_q);
	assign next_val  = opcode[4] ? 8'(mem_q - 8'h01) : 8'(mem_q + 8'h01);

	always_comb begin
		case (opcode[3:2])
			2'b00:   jump_take = 1'b1;
			2'b01:   jump_take = !acc[7];
			2'b10:   jump_take = acc == 8'h00;
			default: jump_take = acc != 8'h00;
		endcase
	end

	always_comb begin
		case (fn)
			`ECD_FN_BCD:  mem_uc = `ECD_UC_MEM_BCD;
			`ECD_FN_ADD:  mem_uc = `ECD_UC_MEM_ADD;
			`ECD_FN_CADD: mem_uc = `ECD_UC_MEM_CADD;
			default:      mem_uc = `ECD_UC_MEM;
		endcase
	end

	always_comb begin
		next_total = `ECD_UC_SHORT;
		if (is_mem) begin
			next_total = is_imm ? 18'(mem_uc - `ECD_UC_IMM_LESS) : mem_uc;
		end else if (is_ext) begin
			next_total = 18'(mem_uc - `ECD_UC_IMM_LESS - `ECD_UC_EXT_LESS);
		end else if (is_incdec) begin
			next_total = `ECD_UC_INCDEC;
		end else if (is_jump) begin
			next_total = jump_take ? `ECD_UC_JUMP : `ECD_UC_NO_JUMP;
		end else if (is_dly) begin
			next_total = 18'(`ECD_UC_DLY_BASE + {9'h000, acc, 1'b0}
				+ 18'(DLY_PER_DATA * {24'h000000, operand}));
		end else if (opcode == `ECD_OP_XAE) begin
			next_total = `ECD_UC_SWAP_EXT;
		end else if (opcode == `ECD_OP_HALT) begin
			next_total = `ECD_UC_HALT;
		end else if ((opcode == `ECD_OP_INT_DIS) || (opcode == `ECD_OP_INT_ALLOW)
			|| (opcode == `ECD_OP_ACC_TO_SR)) begin
			next_total = `ECD_UC_SR_WRITE;
		end else if ((opcode[7:2] == `ECD_PFX_PTR_LOW) || (opcode[7:2] == `ECD_PFX_PTR_HIGH)) begin
			next_total = `ECD_UC_SWAP_PTR;
		end else if (opcode[7:2] == `ECD_PFX_PTR_PC) begin
			next_total = `ECD_UC_SWAP_PC;
		end
	end

	// base for pointer 0 is the PC after the last byte fetch
	ecd_ea u_ea (
		.base      (ptr[p]),
		.disp      (operand),
		.ext       (ext),
		.auto_mode (auto_mode),
		.ea        (ea),
		.new_ptr   (new_ptr)
	);

	ecd_alu u_alu (
		.func (fn),
		.a    (acc),
		.b    (alu_b),
		.cin  (sr_q[`ECD_SR_LINK]),
		.res  (alu_res),
		.cout (alu_cout),
		.ovf  (alu_ovf)
	);

	// pin synchronisers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {serial_in_pin, sense_b_pin, sense_a_pin};
			sync2 <= sync1;
		end
	end

	// microcycles since the instruction fetch was issued
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			elapsed <= 18'h00000;
		end else if (state == S_IDLE && run) begin
			elapsed <= 18'h00000;
		end else if (elapsed != 18'h3FFFF) begin
			elapsed <= 18'(elapsed + 18'h00001);
		end
	end

	assign flag_out = sr_q[2:0];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state          <= S_IDLE;
			for (int i = 0; i < 4; i++) begin
				ptr[i] <= `ECD_PTR_RST;
			end
			acc            <= `ECD_BYTE_RST;
			ext            <= `ECD_BYTE_RST;
			sr_q           <= `ECD_BYTE_RST;
			opcode         <= `ECD_BYTE_RST;
			operand        <= `ECD_BYTE_RST;
			mem_q          <= `ECD_BYTE_RST;
			ea_q           <= `ECD_PTR_RST;
			nptr_q         <= `ECD_PTR_RST;
			post_upd       <= 1'b0;
			total          <= 18'h00000;
			mem_addr       <= `ECD_PTR_RST;
			mem_rd         <= 1'b0;
			mem_wr         <= 1'b0;
			mem_wdata      <= `ECD_BYTE_RST;
			serial_out_pin <= 1'b0;
			halt_pulse     <= 1'b0;
		end else begin
			halt_pulse <= 1'b0;
			case (state)
				S_IDLE: begin
					if (run) begin
						mem_addr <= pc_next;
						mem_rd   <= 1'b1;
						state    <= S_IFW;
					end
				end
				S_IFW: begin
					if (mem_ready) begin
						mem_rd <= 1'b0;
						opcode <= mem_rdata;
						ptr[0] <= pc_next;
						// second byte only for top-bit opcodes
						state  <= mem_rdata[7] ? S_OPF : S_EXEC;
					end
				end
				S_OPF: begin
					mem_addr <= pc_next;
					mem_rd   <= 1'b1;
					state    <= S_OPW;
				end
				S_OPW: begin
					if (mem_ready) begin
						mem_rd  <= 1'b0;
						operand <= mem_rdata;
						ptr[0]  <= pc_next;
						state   <= S_EXEC;
					end
				end
				S_EXEC: begin
					total <= next_total;
					state <= S_PAD;
					if (is_mem && !is_imm) begin
						// one access path for memory and peripherals
						ea_q     <= ea;
						nptr_q   <= new_ptr;
						mem_addr <= ea;
						post_upd <= auto_mode && (ea == ptr[p]);
						if (auto_mode && (ea != ptr[p])) begin
							ptr[p] <= new_ptr;
						end
						if (fn == `ECD_FN_STORE) begin
							mem_wr    <= 1'b1;
							mem_wdata <= acc;
							state     <= S_WRW;
						end else begin
							mem_rd <= 1'b1;
							state  <= S_RDW;
						end
					end else if (is_incdec) begin
						ea_q     <= ea;
						mem_addr <= ea;
						mem_rd   <= 1'b1;
						post_upd <= 1'b0;
						state    <= S_RDW;
					end else if (is_mem || is_ext) begin
						if (fn != `ECD_FN_STORE) begin
							acc <= alu_res;
						end
						if (fn >= `ECD_FN_BCD) begin
							sr_q[`ECD_SR_LINK] <= alu_cout;
						end
						if (fn >= `ECD_FN_ADD) begin
							sr_q[`ECD_SR_OVF] <= alu_ovf;
						end
					end else if (is_jump) begin
						if (jump_take) begin
							ptr[0] <= ea;
						end
					end else if (is_dly) begin
						acc <= `ECD_DLY_END;
					end else begin
						case (opcode)
							`ECD_OP_XAE: begin
								acc <= ext;
								ext <= acc;
							end
							`ECD_OP_HALT:     halt_pulse <= 1'b1;
							`ECD_OP_CLR_LINK: sr_q[`ECD_SR_LINK] <= 1'b0;
							`ECD_OP_SET_LINK: sr_q[`ECD_SR_LINK] <= 1'b1;
							`ECD_OP_INT_DIS:   sr_q[`ECD_SR_IE] <= 1'b0;
							`ECD_OP_INT_ALLOW: sr_q[`ECD_SR_IE] <= 1'b1;
							`ECD_OP_SR_TO_ACC: acc <= sr_view;
							`ECD_OP_ACC_TO_SR: sr_q <= acc;
							`ECD_OP_SERIAL: begin
								ext            <= {sync2[2], ext[7:1]};
								// only this opcode loads the latch
								serial_out_pin <= ext[0];
							end
							`ECD_OP_SHR_ZERO: acc <= {1'b0, acc[7:1]};
							`ECD_OP_SHR_LINK: acc <= {sr_q[`ECD_SR_LINK], acc[7:1]};
							`ECD_OP_ROR:      acc <= {acc[0], acc[7:1]};
							`ECD_OP_ROR_LINK: begin
								acc                <= {sr_q[`ECD_SR_LINK], acc[7:1]};
								sr_q[`ECD_SR_LINK] <= acc[0];
							end
							default: begin
								if (opcode[7:2] == `ECD_PFX_PTR_LOW) begin
									acc         <= ptr[p][7:0];
									ptr[p][7:0] <= acc;
								end else if (opcode[7:2] == `ECD_PFX_PTR_HIGH) begin
									acc          <= ptr[p][15:8];
									ptr[p][15:8] <= acc;
								end else if (opcode[7:2] == `ECD_PFX_PTR_PC) begin
									ptr[0] <= ptr[p];
									ptr[p] <= ptr[0];
								end
							end
						endcase
					end
				end
				S_RDW: begin
					if (mem_ready) begin
						mem_rd <= 1'b0;
						mem_q  <= mem_rdata;
						state  <= S_RES;
					end
				end
				S_RES: begin
					state <= S_PAD;
					if (is_incdec) begin
						acc       <= next_val;
						mem_wdata <= next_val;
						mem_addr  <= ea_q;
						mem_wr    <= 1'b1;
						state     <= S_WRW;
					end else begin
						acc <= alu_res;
						if (fn >= `ECD_FN_BCD) begin
							sr_q[`ECD_SR_LINK] <= alu_cout;
						end
						if (fn >= `ECD_FN_ADD) begin
							sr_q[`ECD_SR_OVF] <= alu_ovf;
						end
						if (post_upd) begin
							ptr[p] <= nptr_q;
						end
					end
				end
				S_WRW: begin
					if (mem_ready) begin
						mem_wr <= 1'b0;
						state  <= S_PAD;
						if (post_upd) begin
							ptr[p] <= nptr_q;
						end
					end
				end
				S_PAD: begin
					// instruction occupies its full microcycle count
					if (18'(elapsed + 18'h00002) >= total) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// register bus, write side
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ECD_RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			run           <= `ECD_CTRL_RUN_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `ECD_REG_CTRL) begin
					s_axi_bresp <= `ECD_RESP_OKAY;
					if (w_strb[0]) begin
						run <= w_data[0];
					end
				end else if (aw_addr == `ECD_REG_STATE) begin
					s_axi_bresp <= `ECD_RESP_OKAY;
				end else begin
					s_axi_bresp <= `ECD_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_got        <= 1'b0;
				w_got         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// register bus, read side
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ECD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `ECD_RESP_OKAY;
			case (s_axi_araddr)
				`ECD_REG_CTRL:  s_axi_rdata <= {31'h00000000, run};
				`ECD_REG_STATE: s_axi_rdata <= {ptr[0], acc, sr_view};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `ECD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

/* File: test/ecd_core_sva.sv */
`timescale 1ns/100ps
module ecd_core_sva (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// memory bus
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	input wire logic [7:0]  mem_rdata,
	input wire logic        mem_ready,
	// pins
	input wire logic        serial_out_pin,
	input wire logic [2:0]  flag_out
);
	logic [7:0] last_rd;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// byte of the latest completed read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			last_rd <= 8'h00;
		else if (mem_rd && mem_ready)
			last_rd <= mem_rdata;
	end
	sequence req_open;
		(mem_rd || mem_wr) && !mem_ready;
	endsequence
	sequence req_taken;
		(mem_rd || mem_wr) && mem_ready;
	endsequence
	req_hold_a: assert property (req_open |=> (mem_rd || mem_wr) && $stable(mem_addr))
		else $error("request not held");
	wdata_hold_a: assert property (mem_wr && !mem_ready |=> mem_wr && $stable(mem_wdata))
		else $error("write data not held");
	one_access_a: assert property (!(mem_rd && mem_wr))
		else $error("read and write together");
	drop_after_a: assert property (req_taken |=> !mem_rd && !mem_wr)
		else $error("request kept after take");
	first_fetch_a: assert property ($rose(rst_n) |-> ##[0:2] (mem_rd && mem_addr == 16'h0001))
		else $error("first fetch missing");
	page_kept_a: assert property ((mem_rd || mem_wr) |-> mem_addr[15:12] == 4'h0)
		else $error("page bits changed");
	serial_src_a: assert property ($changed(serial_out_pin) |-> last_rd == 8'h19)
		else $error("serial latch moved");
	flag_src_a: assert property ($changed(flag_out) |-> last_rd == 8'h07)
		else $error("flags moved");
endmodule

bind ecd_core ecd_core_sva u_sva (.*);

/* File: test/ecd_mem_model.sv */
`timescale 1ns/100ps
module ecd_mem_model (
	// clock
	input wire logic        mclk,
	// bus from the core
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	output logic      [7:0] mem_rdata,
	output logic            mem_ready
);
	logic [7:0] ram [0:65535];
	logic [7:0] last_q = 8'h00;
	logic       slow   = 1'b0;
	logic [1:0] wait_q = 2'h0;
	// one space for memory and peripherals
	assign mem_ready = (mem_rd || mem_wr) && (!slow || wait_q == 2'h2);
	// a released bus shows the inverse of the last byte
	assign mem_rdata = (mem_rd && mem_ready) ? ram[mem_addr] : ~last_q;
	always @(posedge mclk) begin
		wait_q <= ((mem_rd || mem_wr) && !mem_ready) ? wait_q + 2'h1 : 2'h0;
		if (mem_rd && mem_ready)
			last_q <= ram[mem_addr];
		if (mem_wr && mem_ready)
			ram[mem_addr] <= mem_wdata;
	end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] mem_addr;
	logic        mem_rd, mem_wr, mem_ready, serial_out_pin, halt_pulse;
	logic [7:0]  mem_wdata, mem_rdata;
	logic [2:0]  flag_out;
	logic        sense_a_pin = 1'b1;
	logic        sense_b_pin = 1'b0;
	logic        serial_in_pin = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          n_fail = 0;
	int          n_tests = 0;
	int          n_halt = 0;
	int          cyc = 0;
	int          t_at [int];
	logic        rd_q = 1'b0;
	localparam logic [7:0] PROG [46] = '{
		8'hC4, 8'h03, 8'h8F, 8'h02, 8'hC4, 8'h55, 8'hC8, 8'h40, 8'hF4, 8'hAB,
		8'hEC, 8'h19, 8'h01, 8'hC0, 8'h80, 8'h1E, 8'h01, 8'h19, 8'hC4, 8'h40,
		8'h31, 8'hC4, 8'h77, 8'hCD, 8'hFF, 8'hC4, 8'h00, 8'hC5, 8'h01, 8'hC1,
		8'h02, 8'hA8, 8'h30, 8'h31, 8'hC8, 8'h3C, 8'h98, 8'h02, 8'h9C, 8'h00,
		8'hC4, 8'h0F, 8'h07, 8'h00, 8'h90, 8'hFD};

	ecd_core #(.DLY_PER_DATA(2)) dut (.*);
	ecd_mem_model mem (.*);

	initial begin
		forever #10 mclk = ~mclk;
	end
	// first read issue cycle of each address
	always @(posedge mclk) begin
		cyc++;
		if (mem_rd && !rd_q && !t_at.exists(mem_addr))
			t_at[mem_addr] = cyc;
		rd_q = mem_rd;
		if (halt_pulse)
			n_halt++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// program run with prompt or slow memory
	task automatic run_prog(input logic sl);
		logic [31:0] d;
		logic [1:0]  r;
		rst_n <= 1'b0;
		t_at.delete();
		n_halt = 0;
		mem.slow = sl;
		for (int i = 0; i < 4096; i++)
			mem.ram[i] = 8'h00;
		for (int i = 0; i < 46; i++)
			mem.ram[i + 1] = PROG[i];
		mem.ram[16'h002F] = 8'h3B;
		mem.ram[16'h0042] = 8'hA5;
		mem.ram[16'h0051] = 8'h7F;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (700) @(posedge mclk);
		axi_wr(4'h0, 32'h0);
		chk(s_axi_bresp, 2'h0, "ctrl write resp");
		repeat (30) @(posedge mclk);
		chk(n_halt > 0, 1'b1, "halt pulses");
		axi_rd(4'h4, d, r);
		chk(d[15:0], 16'h0F1F, "acc and status");
		chk(mem.ram[16'h0048], 8'h55, "relative store");
		chk(mem.ram[16'h003F], 8'h77, "step down store");
		chk(mem.ram[16'h0060], 8'h40, "pointer kept");
		chk(mem.ram[16'h0051], 8'h80, "incr fetch");
		chk(serial_out_pin, 1'b1, "serial latch");
		chk(flag_out, 3'h7, "flags");
		if (!sl) begin
			chk(t_at[16'h05] - t_at[16'h03], 23, "wait span");
			chk(t_at[16'h27] - t_at[16'h25], 9, "not taken");
			chk(t_at[16'h29] - t_at[16'h27], 11, "taken");
		end
		@(posedge mclk);
		axi_rd(4'h8, d, r);
		chk(r, 2'h2, "unmapped resp");
		chk(d, 32'h0, "unmapped data");
	endtask

	initial begin
		run_prog(1'b0);
		run_prog(1'b1);
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		tally_and_finish();
	end
endmodule
